// [rtl/esp_pkg.sv]
// Purpose: Constants for the engine speed protection monitor
// Assumes: 40 MHz clock, speed in rpm, charge voltage in units of 0.1 V
// Notes:   Timer settings are in whole seconds
package esp_pkg;
    localparam int unsigned CLK_HZ            = 32'h0262_5A00;
    localparam int unsigned SEC_CYCLES        = CLK_HZ;
    localparam logic [15:0] NOM_RPM_DEF       = 16'h05DC;  // 1500 rpm
    localparam logic [15:0] NOM_RPM_ALT_DEF   = 16'h0708;  // 1800 rpm
    localparam logic [7:0]  LOW_WARN_PCT_DEF  = 8'h0A;     // 10 %
    localparam logic [7:0]  HIGH_WARN_PCT_DEF = 8'h0A;     // 10 %
    localparam logic [7:0]  LOW_SD_PCT_DEF    = 8'h0F;     // 15 %
    localparam logic [7:0]  HIGH_SD_PCT_DEF   = 8'h0F;     // 15 %
    localparam logic [7:0]  OVERSHOOT_PCT_DEF = 8'h0A;     // 10 %
    localparam logic [7:0]  SPEED_FAIL_S_DEF  = 8'h03;
    localparam logic [7:0]  SPEED_FAIL_S_MAX  = 8'h0A;
    localparam logic [7:0]  LOS_S_DEF         = 8'h00;
    localparam logic [7:0]  LOS_S_MAX         = 8'hF0;
    localparam logic [9:0]  CHG_WARN_DEF      = 10'h03C;   // 6.0 V
    localparam logic [9:0]  CHG_SD_DEF        = 10'h028;   // 4.0 V
    localparam logic [9:0]  CHG_MAX           = 10'h190;   // 40.0 V
    localparam logic [7:0]  CHG_FAIL_S_DEF    = 8'h01;
    localparam logic [7:0]  CHG_FAIL_S_MAX    = 8'h78;
    localparam logic [1:0]  FREQ_PRIMARY      = 2'h0;
    localparam logic [1:0]  FREQ_SECONDARY    = 2'h1;
    localparam logic [1:0]  FREQ_TERTIARY     = 2'h2;
    localparam logic [1:0]  LOS_ACT_SHUTDOWN  = 2'h0;
    localparam logic [1:0]  LOS_ACT_LOADDUMP  = 2'h1;
    localparam logic [1:0]  LOS_ACT_WARNING   = 2'h2;
    localparam logic [6:0]  PCT_FULL          = 7'h64;     // 100 %
endpackage

// [rtl/esp_fail_timer.sv]
// Purpose: Seconds-based fail timer for one monitored condition
// Assumes: tick_in pulses once per second
// Notes:   Restarts whenever the condition clears
`timescale 1ns/10ps
module esp_fail_timer #(
    parameter int W = 8
) (
    input  wire logic         ref_clk_in,
    input  wire logic         rst_in,
    input  wire logic         cond_in,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] limit_s_in,
    output logic              expired_out
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    always_comb begin
        cnt_next = cnt_reg;
        if (!cond_in) begin
            cnt_next = '0;
        end else if (tick_in && cnt_reg < limit_s_in) begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign expired_out = cond_in && (cnt_reg >= limit_s_in);
endmodule

// [rtl/esp_monitor.sv]
// Purpose: Engine speed, speed signal and charge voltage protection
// Assumes: speed_rpm_in and charge_dv_in are same-clock samples; ack_in clears latches
// Notes:   Percent limits are magnitudes relative to the nominal speed, except overshoot, which is relative to the high shutdown level
`timescale 1ns/10ps
module esp_monitor #(
    parameter int SEC_CYCLES = esp_pkg::SEC_CYCLES
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] speed_rpm_in,
    input  wire logic        speed_valid_in,
    input  wire logic [9:0]  charge_dv_in,
    input  wire logic        feeding_load_in,
    input  wire logic        engine_running_in,
    input  wire logic        idle_active_in,
    input  wire logic [1:0]  freq_sel_in,
    input  wire logic [15:0] nom_rpm_in,
    input  wire logic [15:0] nom_rpm2_in,
    input  wire logic [15:0] nom_rpm3_in,
    input  wire logic [7:0]  low_warn_pct_in,
    input  wire logic [7:0]  low_sd_pct_in,
    input  wire logic [7:0]  high_warn_pct_in,
    input  wire logic [7:0]  high_sd_pct_in,
    input  wire logic [7:0]  overshoot_pct_in,
    input  wire logic [7:0]  speed_fail_s_in,
    input  wire logic        los_check_in,
    input  wire logic [1:0]  los_action_in,
    input  wire logic [7:0]  los_s_in,
    input  wire logic [9:0]  chg_warn_dv_in,
    input  wire logic [9:0]  chg_sd_dv_in,
    input  wire logic [7:0]  chg_fail_s_in,
    input  wire logic        ack_in,
    output logic             low_speed_warn_out,
    output logic             high_speed_warn_out,
    output logic             low_speed_sd_out,
    output logic             high_speed_sd_out,
    output logic             los_sd_out,
    output logic             los_loaddump_out,
    output logic             los_warn_out,
    output logic             chg_warn_out,
    output logic             chg_sd_out,
    output logic             stop_engine_out,
    output logic             load_dump_out,
    output logic [16:0]      upper_speed_trip_level_out
);
    // Fail timer slots
    localparam int N_TMR        = 6;
    localparam int TMR_LOW_WARN = 0;
    localparam int TMR_LOW_SD   = 1;
    localparam int TMR_HIGH     = 2;
    localparam int TMR_LOS      = 3;
    localparam int TMR_CHG_WARN = 4;
    localparam int TMR_CHG_SD   = 5;

    // Scale a nominal by (100 +/- pct) / 100
    function automatic logic [16:0] scale_pct(input logic [15:0] nom, input logic [7:0] pct, input logic up);
        logic [24:0] prod;
        logic [8:0]  factor;
        factor = up ? (9'(esp_pkg::PCT_FULL) + 9'(pct))
                    : ((pct > 8'(esp_pkg::PCT_FULL)) ? 9'h000 : (9'(esp_pkg::PCT_FULL) - 9'(pct)));
        prod = 25'(nom) * 25'(factor);
        return 17'(prod / 25'(esp_pkg::PCT_FULL));
    endfunction

    // Clamp a timer setting to its maximum
    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] mx);
        return (v > mx) ? mx : v;
    endfunction

    // Seconds limit of one fail timer slot
    function automatic logic [7:0] tmr_limit(input int idx, input logic [7:0] spd_s,
                                             input logic [7:0] los_s, input logic [7:0] chg_s);
        logic [7:0] sel;
        case (idx)
            TMR_LOS:                  sel = los_s;
            TMR_CHG_WARN, TMR_CHG_SD: sel = chg_s;
            default:                  sel = spd_s;
        endcase
        return sel;
    endfunction

    logic [31:0] tick_cnt_reg;
    logic [31:0] tick_cnt_next;
    logic        tick;
    logic [15:0] nom_rpm;
    logic [16:0] low_warn_lvl;
    logic [16:0] low_sd_lvl;
    logic [16:0] high_warn_lvl;
    logic [16:0] high_sd_lvl;
    logic [24:0] over_prod;
    logic [16:0] over_lvl;
    logic [16:0] speed;
    logic        low_chk_ok;
    logic        c_low_warn;
    logic        c_high_warn;
    logic        c_low_sd;
    logic        c_high_sd;
    logic        c_over;
    logic        c_los;
    logic        c_chg_warn;
    logic        c_chg_sd;
    logic [9:0]  chg_warn_lim;
    logic [9:0]  chg_sd_lim;
    logic [7:0]  spd_lim_s;
    logic [7:0]  los_lim_s;
    logic [7:0]  chg_lim_s;
    logic [5:0]  cond_vec;
    logic [5:0]  exp_vec;
    logic        los_act_sd;
    logic        los_act_ld;
    logic        los_act_warn;
    logic        stop_reg;
    logic        stop_next;
    logic        dump_reg;
    logic        dump_next;
    logic [16:0] trip_reg;
    logic [16:0] trip_next;

    typedef struct packed {
        logic lw;
        logic hw;
        logic lsd;
        logic hsd;
        logic lsd_los;
        logic ld_los;
        logic w_los;
        logic cw;
        logic csd;
    } esp_flags_t;

    esp_flags_t flags_reg;
    esp_flags_t flags_next;

    // One-second timebase
    always_comb begin
        tick          = (tick_cnt_reg == 32'(SEC_CYCLES - 1));
        tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tick_cnt_reg <= 32'h0000_0000;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
        end
    end

    // Limit reference and window levels
    always_comb begin
        unique case (freq_sel_in)
            esp_pkg::FREQ_SECONDARY: nom_rpm = nom_rpm2_in;
            esp_pkg::FREQ_TERTIARY:  nom_rpm = nom_rpm3_in;
            default:                 nom_rpm = nom_rpm_in;
        endcase
        low_warn_lvl  = scale_pct(nom_rpm, low_warn_pct_in, 1'b0);
        high_warn_lvl = scale_pct(nom_rpm, high_warn_pct_in, 1'b1);
        low_sd_lvl    = scale_pct(nom_rpm, low_sd_pct_in, 1'b0);
        high_sd_lvl   = scale_pct(nom_rpm, high_sd_pct_in, 1'b1);
        over_prod     = 25'(high_sd_lvl) * (25'(esp_pkg::PCT_FULL) + 25'(overshoot_pct_in));
        over_lvl      = 17'(over_prod / 25'(esp_pkg::PCT_FULL));
        trip_next     = high_sd_lvl;
    end

    // Speed window and signal conditions
    always_comb begin
        speed         = {1'b0, speed_rpm_in};
        low_chk_ok    = !idle_active_in;
        c_low_warn    = feeding_load_in && low_chk_ok && speed < low_warn_lvl;
        c_high_warn   = feeding_load_in && speed > high_warn_lvl;
        c_low_sd      = feeding_load_in && low_chk_ok && speed < low_sd_lvl;
        c_high_sd     = feeding_load_in && speed > high_sd_lvl;
        c_over        = speed_valid_in && speed > over_lvl;
        c_los         = los_check_in && engine_running_in && !speed_valid_in;
    end

    // Charge conditions and timer limits
    always_comb begin
        chg_warn_lim  = (chg_warn_dv_in > esp_pkg::CHG_MAX) ? esp_pkg::CHG_MAX : chg_warn_dv_in;
        chg_sd_lim    = (chg_sd_dv_in > esp_pkg::CHG_MAX) ? esp_pkg::CHG_MAX : chg_sd_dv_in;
        c_chg_warn    = engine_running_in && low_chk_ok && charge_dv_in < chg_warn_lim;
        c_chg_sd      = engine_running_in && low_chk_ok && charge_dv_in < chg_sd_lim;
        spd_lim_s     = clamp8(speed_fail_s_in, esp_pkg::SPEED_FAIL_S_MAX);
        los_lim_s     = clamp8(los_s_in, esp_pkg::LOS_S_MAX);
        chg_lim_s     = clamp8(chg_fail_s_in, esp_pkg::CHG_FAIL_S_MAX);
    end

    // Pack timer conditions by slot
    always_comb begin
        cond_vec               = 6'h00;
        cond_vec[TMR_LOW_WARN] = c_low_warn;
        cond_vec[TMR_LOW_SD]   = c_low_sd;
        cond_vec[TMR_HIGH]     = c_high_sd || c_high_warn;
        cond_vec[TMR_LOS]      = c_los;
        cond_vec[TMR_CHG_WARN] = c_chg_warn;
        cond_vec[TMR_CHG_SD]   = c_chg_sd;
    end

    // One fail timer per slot
    genvar gi;
    generate
        for (gi = 0; gi < N_TMR; gi++) begin : g_tmr
            logic [7:0] lim;
            assign lim = tmr_limit(gi, spd_lim_s, los_lim_s, chg_lim_s);
            esp_fail_timer #(
                .W (8)
            ) u_tmr (
                .ref_clk_in  (ref_clk_in),
                .rst_in      (rst_in),
                .cond_in     (cond_vec[gi]),
                .tick_in     (tick),
                .limit_s_in  (lim),
                .expired_out (exp_vec[gi])
            );
        end
    endgenerate

    // Signal lost action decode
    always_comb begin
        los_act_sd   = (los_action_in == esp_pkg::LOS_ACT_SHUTDOWN);
        los_act_ld   = (los_action_in == esp_pkg::LOS_ACT_LOADDUMP);
        los_act_warn = (los_action_in == esp_pkg::LOS_ACT_WARNING);
    end

    // Fault flags
    always_comb begin
        flags_next = flags_reg;
        // Warnings follow their timed condition
        flags_next.lw    = exp_vec[TMR_LOW_WARN];
        flags_next.hw    = exp_vec[TMR_HIGH] && c_high_warn;
        flags_next.cw    = exp_vec[TMR_CHG_WARN];
        flags_next.w_los = exp_vec[TMR_LOS] && los_act_warn;
        // Latched faults clear on acknowledge
        if (ack_in) begin
            flags_next.lsd     = 1'b0;
            flags_next.hsd     = 1'b0;
            flags_next.lsd_los = 1'b0;
            flags_next.ld_los  = 1'b0;
            flags_next.csd     = 1'b0;
        end
        // Set wins over acknowledge
        if (exp_vec[TMR_LOW_SD]) begin
            flags_next.lsd = 1'b1;
        end
        if ((exp_vec[TMR_HIGH] && c_high_sd) || c_over) begin
            flags_next.hsd = 1'b1;
        end
        if (exp_vec[TMR_LOS] && los_act_sd) begin
            flags_next.lsd_los = 1'b1;
        end
        if (exp_vec[TMR_LOS] && los_act_ld) begin
            flags_next.ld_los = 1'b1;
        end
        if (exp_vec[TMR_CHG_SD]) begin
            flags_next.csd = 1'b1;
        end
        // Engine stop and load dump registered beside the flags
        stop_next = flags_next.lsd || flags_next.hsd || flags_next.lsd_los || flags_next.csd;
        dump_next = flags_next.ld_los;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            flags_reg <= '0;
            stop_reg  <= 1'b0;
            dump_reg  <= 1'b0;
            trip_reg  <= 17'h00000;
        end else begin
            flags_reg <= flags_next;
            stop_reg  <= stop_next;
            dump_reg  <= dump_next;
            trip_reg  <= trip_next;
        end
    end

    // Outputs straight from registers

    assign low_speed_warn_out  = flags_reg.lw;
    assign high_speed_warn_out = flags_reg.hw;
    assign low_speed_sd_out    = flags_reg.lsd;
    assign high_speed_sd_out   = flags_reg.hsd;
    assign los_sd_out          = flags_reg.lsd_los;
    assign los_loaddump_out    = flags_reg.ld_los;
    assign los_warn_out        = flags_reg.w_los;
    assign chg_warn_out        = flags_reg.cw;
    assign chg_sd_out          = flags_reg.csd;
    assign stop_engine_out     = stop_reg;
    assign load_dump_out       = dump_reg;
    assign upper_speed_trip_level_out = trip_reg;
endmodule

// [bench/esp_checker.sv]
// Purpose: Port assertions for the speed protection monitor
// Assumes: Settings held steady while a relation is checked
// Notes:   Bound to esp_monitor
`timescale 1ns/10ps
module esp_checker (
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    input wire logic [15:0] speed_rpm_in,
    input wire logic        speed_valid_in,
    input wire logic        engine_running_in,
    input wire logic        idle_active_in,
    input wire logic [1:0]  freq_sel_in,
    input wire logic [15:0] nom_rpm_in,
    input wire logic [15:0] nom_rpm2_in,
    input wire logic [15:0] nom_rpm3_in,
    input wire logic [7:0]  high_sd_pct_in,
    input wire logic [7:0]  overshoot_pct_in,
    input wire logic        los_check_in,
    input wire logic [1:0]  los_action_in,
    input wire logic [7:0]  los_s_in,
    input wire logic        ack_in,
    input wire logic        low_speed_warn_out,
    input wire logic        low_speed_sd_out,
    input wire logic        high_speed_sd_out,
    input wire logic        los_sd_out,
    input wire logic        los_loaddump_out,
    input wire logic        los_warn_out,
    input wire logic        chg_warn_out,
    input wire logic        chg_sd_out,
    input wire logic        stop_engine_out,
    input wire logic        load_dump_out,
    input wire logic [16:0] upper_speed_trip_level_out
);
    int unsigned nom_x;
    int unsigned lvl_x;
    int unsigned ovs_x;
    always_comb begin
        nom_x = (freq_sel_in == esp_pkg::FREQ_SECONDARY) ? nom_rpm2_in
              : ((freq_sel_in == esp_pkg::FREQ_TERTIARY) ? nom_rpm3_in : nom_rpm_in);
        lvl_x = nom_x * (100 + high_sd_pct_in) / 100;
        ovs_x = lvl_x * (100 + overshoot_pct_in) / 100;
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    stop_or_a: assert property (stop_engine_out == (low_speed_sd_out || high_speed_sd_out
        || los_sd_out || chg_sd_out)) else $error("stop output mismatch");
    dump_eq_a: assert property (load_dump_out == los_loaddump_out) else $error("load dump mismatch");
    ovs_fast_a: assert property (speed_valid_in && speed_rpm_in > ovs_x
        |=> high_speed_sd_out) else $error("overshoot not immediate");
    latch_hold_a: assert property ($fell(low_speed_sd_out) || $fell(high_speed_sd_out) || $fell(los_sd_out)
        || $fell(chg_sd_out) || $fell(los_loaddump_out) |-> $past(ack_in) || $past(rst_in))
        else $error("latched fault dropped");
    idle_low_a: assert property (idle_active_in [*3] |-> !low_speed_warn_out && !chg_warn_out)
        else $error("low check during idle");
    los_off_a: assert property (!los_check_in [*3] |-> !los_warn_out) else $error("loss warned while off");
    los_zero_a: assert property ((los_check_in && engine_running_in && !speed_valid_in && los_s_in == 8'h00
        && los_action_in == esp_pkg::LOS_ACT_WARNING) [*3] |-> los_warn_out) else $error("loss warning late");
    trip_lvl_a: assert property ((freq_sel_in == 2'h0 && $stable(nom_rpm_in) && $stable(high_sd_pct_in)) [*3]
        |-> upper_speed_trip_level_out == lvl_x[16:0]) else $error("trip level wrong");
    cover property (high_speed_sd_out);
    cover property (los_loaddump_out);
    cover property (chg_sd_out);
    cover property (low_speed_warn_out);
endmodule
bind esp_monitor esp_checker esp_checker_i (.*);

// [bench/esp_engine_model.sv]
// Purpose: Speed pickup and charge sensing seen from the engine
// Assumes: Readings are registered on the monitor clock
// Notes:   A lost pickup shows a changing pattern, not the last reading
`timescale 1ns/10ps
module esp_engine_model (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic [15:0] rpm_in,
    input  wire logic        present_in,
    input  wire logic [9:0]  volt_in,
    output logic      [15:0] speed_rpm_out,
    output logic             speed_valid_out,
    output logic      [9:0]  charge_dv_out
);
    always_ff @(posedge ref_clk_in) begin
        speed_valid_out <= present_in;
        charge_dv_out   <= volt_in;
        speed_rpm_out   <= rst_in ? 16'h0000 : (present_in ? rpm_in : ~speed_rpm_out);
    end
endmodule

// [bench/testbench.sv]
// Purpose: Scenario bench for the speed protection monitor
// Assumes: One second shortened to ten cycles
// Notes:   Flags sampled 1 ns after the edge
`timescale 1ns/10ps
module testbench;
    logic ref_clk_in = 0, rst_in = 1, present = 1, ack_in = 0, idle_active_in = 0, los_check_in = 0;
    logic feeding_load_in = 0, engine_running_in = 0, speed_valid_in;
    logic [15:0] rpm = 16'h05DC, speed_rpm_in, nom_rpm_in = esp_pkg::NOM_RPM_DEF;
    logic [15:0] nom_rpm2_in = esp_pkg::NOM_RPM_ALT_DEF, nom_rpm3_in = 16'h07D0;
    logic [9:0]  volt = 10'h078, charge_dv_in, chg_warn_dv_in = esp_pkg::CHG_WARN_DEF;
    logic [9:0]  chg_sd_dv_in = esp_pkg::CHG_SD_DEF;
    logic [7:0]  low_warn_pct_in = 8'h0A, high_warn_pct_in = 8'h0A, low_sd_pct_in = 8'h0F, high_sd_pct_in = 8'h0F;
    logic [7:0]  overshoot_pct_in = 8'h0A, speed_fail_s_in = 8'h03, los_s_in = 8'h00, chg_fail_s_in = 8'h01;
    logic [1:0]  freq_sel_in = 2'h0, los_action_in = 2'h0;
    logic low_speed_warn_out, high_speed_warn_out, low_speed_sd_out, high_speed_sd_out, los_sd_out;
    logic los_loaddump_out, los_warn_out, chg_warn_out, chg_sd_out, stop_engine_out, load_dump_out;
    logic [16:0] upper_speed_trip_level_out;
    logic [16:0] lv [4] = '{17'h006BD, 17'h00816, 17'h008FC, 17'h006BD};
    wire  [8:0]  flags = {chg_sd_out, chg_warn_out, los_warn_out, los_loaddump_out, los_sd_out,
                          high_speed_sd_out, low_speed_sd_out, high_speed_warn_out, low_speed_warn_out};
    int errors = 0, n_tests = 0, cycles = 0;
    esp_monitor #(.SEC_CYCLES(10)) esp_monitor_i (.*);
    esp_engine_model esp_engine_model_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .rpm_in(rpm),
        .present_in(present), .volt_in(volt), .speed_rpm_out(speed_rpm_in),
        .speed_valid_out(speed_valid_in), .charge_dv_out(charge_dv_in));
    always #12.5 ref_clk_in = ~ref_clk_in;
    task end_sim;
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            end_sim;
        end
    end
    task chk(input logic [16:0] got, input logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic rise(input int b, input int lo, input int hi);
        int c = 0;
        while (flags[b] !== 1'b1 && c < hi) begin
            cyc(1);
            c++;
        end
        chk(flags[b], 1'b1);
        chk(c >= lo, 1'b1);
    endtask
    task ack;
        @(posedge ref_clk_in) ack_in <= 1'b1;
        @(posedge ref_clk_in) ack_in <= 1'b0;
        cyc(2);
    endtask
    task t_level;
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk_in) freq_sel_in <= i[1:0];
            cyc(4);
            chk(upper_speed_trip_level_out, lv[i]);
        end
        @(posedge ref_clk_in) freq_sel_in <= 2'h0;
    endtask
    task t_speed;
        @(posedge ref_clk_in) feeding_load_in <= 1'b1;
        rpm <= 16'h053C;
        cyc(15);
        chk(low_speed_warn_out, 1'b0);
        @(posedge ref_clk_in) rpm <= 16'h05DC;
        cyc(3);
        @(posedge ref_clk_in) rpm <= 16'h053C;
        rise(0, 18, 40);
        @(posedge ref_clk_in) rpm <= 16'h067C;
        rise(1, 18, 40);
        chk(low_speed_warn_out, 1'b0);
        @(posedge ref_clk_in) rpm <= 16'h04B0;
        rise(2, 18, 40);
        chk(stop_engine_out, 1'b1);
        @(posedge ref_clk_in) rpm <= 16'h05DC;
        feeding_load_in <= 1'b0;
        cyc(5);
        chk(low_speed_sd_out, 1'b1);
        ack;
        chk(low_speed_sd_out, 1'b0);
        @(posedge ref_clk_in) rpm <= 16'h076A;
        rise(3, 0, 3);
        @(posedge ref_clk_in) rpm <= 16'h05DC;
        ack;
        chk(high_speed_sd_out, 1'b0);
    endtask
    task t_los;
        @(posedge ref_clk_in) engine_running_in <= 1'b1;
        present <= 1'b0;
        cyc(10);
        chk(flags[6:4], 3'h0);
        for (int a = 0; a < 3; a++) begin
            @(posedge ref_clk_in) los_action_in <= a[1:0];
            los_check_in <= 1'b1;
            rise(4 + a, 0, 4);
            chk(stop_engine_out, a == 0);
            chk(load_dump_out, a == 1);
            cyc(3);
            @(posedge ref_clk_in) los_check_in <= 1'b0;
            ack;
            chk(flags[6:4], 3'h0);
        end
        @(posedge ref_clk_in) los_s_in <= 8'h02;
        los_check_in <= 1'b1;
        rise(6, 9, 30);
        @(posedge ref_clk_in) los_check_in <= 1'b0;
        present <= 1'b1;
        cyc(3);
    endtask
    task t_chg;
        @(posedge ref_clk_in) volt <= 10'h037;
        rise(7, 0, 15);
        chk(chg_sd_out, 1'b0);
        @(posedge ref_clk_in) volt <= 10'h023;
        rise(8, 0, 15);
        chk(stop_engine_out, 1'b1);
        @(posedge ref_clk_in) volt <= 10'h078;
        ack;
        @(posedge ref_clk_in) idle_active_in <= 1'b1;
        feeding_load_in <= 1'b1;
        rpm <= 16'h053C;
        volt <= 10'h037;
        cyc(40);
        chk(flags[7] | flags[0], 1'b0);
        @(posedge ref_clk_in) idle_active_in <= 1'b0;
        rise(7, 0, 15);
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        t_level;
        t_speed;
        t_los;
        t_chg;
        end_sim;
    end
endmodule
